// ---- tdcrf_consts.vh ----
`ifndef TDCRF_CONSTS_VH
`define TDCRF_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Channel and buffer geometry
`define TDCRF_CHANNELS      4
`define TDCRF_FIFO_MAX      16
`define TDCRF_PTR_W         4
`define TDCRF_CNT_W         5
`define TDCRF_DEPTH_OFF     5'h10
`define TDCRF_DEPTH_X2      5'h08
`define TDCRF_DEPTH_X4      5'h04

////////////////////////////////////////////////////////////////////////////////
// Resolution setting encodings
`define TDCRF_RES_X2        2'h1
`define TDCRF_RES_X4        2'h2

////////////////////////////////////////////////////////////////////////////////
// Restart after overflow or block drain
`define TDCRF_RESTART_STOPS 2'h2
`define TDCRF_RESTART_NONE  2'h0

////////////////////////////////////////////////////////////////////////////////
// Result word layout
`define TDCRF_TIME_W        24
`define TDCRF_ENTRY_W       48
`define TDCRF_TICK_W        16
`define TDCRF_PIN_W         5

////////////////////////////////////////////////////////////////////////////////
// Clock rate and conversion latency
`define TDCRF_CLK_MHZ       250
`define TDCRF_CONV_NS_OFF   200
`define TDCRF_CONV_NS_X2    400
`define TDCRF_CONV_NS_X4    800
`define TDCRF_NS_TO_CYC(ns) ((((ns) * `TDCRF_CLK_MHZ) + 999) / 1000)

`endif

// ---- tdcrf_pin_sync.v ----
`timescale 1ns/1ps
`include "tdcrf_consts.vh"

module tdcrf_pin_sync #(
  parameter W = `TDCRF_PIN_W
) (
  // Clock and reset
  input  wire         clock_in,
  input  wire         resetn_in,
  // Asynchronous pins
  input  wire [W-1:0] pin_in,
  // Filtered level and rising-edge pulse
  output wire [W-1:0] level_out,
  output wire [W-1:0] rise_out
);

  reg [W-1:0] s1_reg;    // First stage, read only by second
  reg [W-1:0] s2_reg;    // Second stage
  reg [W-1:0] s3_reg;    // Third stage
  reg [W-1:0] level_reg; // Accepted level
  reg [W-1:0] rise_reg;  // One-cycle rising pulse

  ////////////////////////////////////////////////////////////////////////////////
  // Three flops; a change counts only once stages two and three agree,
  // which rejects a single-cycle glitch at the cost of one cycle latency
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_reg    <= {W{1'b0}};
      s2_reg    <= {W{1'b0}};
      s3_reg    <= {W{1'b0}};
      level_reg <= {W{1'b0}};
      rise_reg  <= {W{1'b0}};
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= (s2_reg & s3_reg) | ((s2_reg | s3_reg) & level_reg);
      rise_reg  <= s2_reg & s3_reg & ~level_reg;
    end
  end

  assign level_out = level_reg;
  assign rise_out  = rise_reg;

endmodule // tdcrf_pin_sync

// ---- tdcrf_skid.v ----
`timescale 1ns/1ps
`include "tdcrf_consts.vh"

module tdcrf_skid #(
  parameter W = `TDCRF_ENTRY_W + 2
) (
  // Clock and reset
  input  wire         clock_in,
  input  wire         resetn_in,
  // Fill side
  input  wire         in_valid_in,
  input  wire [W-1:0] in_data_in,
  output wire         in_ready_out,
  // Drain side
  output wire         out_valid_out,
  output wire [W-1:0] out_data_out,
  input  wire         out_ready_in
);

  reg [W-1:0] head_reg;  // Oldest word
  reg [W-1:0] tail_reg;  // Second word
  reg [1:0]   count_reg; // Words held, 0 to 2

  wire push = in_valid_in & (count_reg != 2'h2);
  wire pop  = out_ready_in & (count_reg != 2'h0);

  ////////////////////////////////////////////////////////////////////////////////
  // Two entries so a stalled receiver never costs a word already popped
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      head_reg  <= {W{1'b0}};
      tail_reg  <= {W{1'b0}};
      count_reg <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          // Fill the first free slot
          if (count_reg == 2'h0) begin
            head_reg <= in_data_in;
          end else begin
            tail_reg <= in_data_in;
          end
          count_reg <= count_reg + 2'h1;
        end
        2'b01: begin
          // Shift tail forward
          head_reg  <= tail_reg;
          count_reg <= count_reg - 2'h1;
        end
        2'b11: begin
          // Only reachable with one word held; count unchanged
          head_reg <= in_data_in;
        end
        default: begin
        end
      endcase
    end
  end

  assign in_ready_out  = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out  = head_reg;

endmodule // tdcrf_skid

// ---- tdcrf_result_fifo.v ----
`timescale 1ns/1ps
`include "tdcrf_consts.vh"

module tdcrf_result_fifo (
  // Clock and reset
  input  wire                       clock_in,
  input  wire                       resetn_in,
  // Measurement pins, asynchronous
  input  wire [3:0]                 stop_pin_in,
  input  wire                       ref_clock_pin_in,
  // Configuration
  input  wire [1:0]                 resolution_boost_setting_in,
  input  wire                       block_drain_mode_in,
  input  wire                       joint_read_mode_in,
  input  wire [3:0]                 channel_active_in,
  input  wire                       init_in,
  // Read request from the serial front end
  input  wire                       rd_req_in,
  input  wire [1:0]                 rd_chan_in,
  output wire                       rd_accept_out,
  // Result stream
  output wire                       res_valid_out,
  input  wire                       res_ready_in,
  output wire [1:0]                 res_chan_out,
  output wire [`TDCRF_TIME_W-1:0]   reference_period_index_out,
  output wire [`TDCRF_TIME_W-1:0]   stop_time_value_out,
  // Status
  output wire                       results_ready_n_out,
  output wire [4*`TDCRF_CNT_W-1:0]  fill_level_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Latency counts per resolution setting, rounded up to whole cycles
  localparam [`TDCRF_TICK_W-1:0] LAT_OFF = `TDCRF_NS_TO_CYC(`TDCRF_CONV_NS_OFF);
  localparam [`TDCRF_TICK_W-1:0] LAT_X2  = `TDCRF_NS_TO_CYC(`TDCRF_CONV_NS_X2);
  localparam [`TDCRF_TICK_W-1:0] LAT_X4  = `TDCRF_NS_TO_CYC(`TDCRF_CONV_NS_X4);

  wire [`TDCRF_PIN_W-1:0]   pin_rise;         // Rising-edge pulses
  wire [3:0]                stop_rise;        // Stop edges per channel
  wire                      ref_rise;         // Reference clock edge
  reg  [`TDCRF_TIME_W-1:0]  period_idx_reg;   // Reference periods counted
  reg  [`TDCRF_TIME_W-1:0]  since_ref_reg;    // Cycles since last reference edge
  reg  [`TDCRF_TICK_W-1:0]  tick_reg;         // Free-running age base
  reg  [`TDCRF_CNT_W-1:0]   depth;            // Usable depth
  reg  [`TDCRF_TICK_W-1:0]  lat;              // Conversion latency in cycles
  wire [3:0]                ch_ready;         // Channel offers data
  wire [4*`TDCRF_ENTRY_W-1:0] head_data;      // Head word per channel
  wire [3:0]                sel_oh;           // One-hot read channel
  wire                      skid_in_ready;    // Buffer can take a word
  wire                      any_ready;        // Some channel offers data
  wire                      all_ready;        // Every active channel offers data
  wire                      group_ready;      // Ready per selected read mode
  wire                      rd_fire;          // Pop this cycle
  reg                       ready_n_reg;      // Registered ready pin
  wire [`TDCRF_ENTRY_W+1:0] skid_out;         // Buffer output word

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: four stops plus reference clock
  tdcrf_pin_sync u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .pin_in    ({ref_clock_pin_in, stop_pin_in}),
    .level_out (),
    .rise_out  (pin_rise)
  );

  assign stop_rise = pin_rise[3:0];
  assign ref_rise  = pin_rise[4];

  ////////////////////////////////////////////////////////////////////////////////
  // Time base: period index and fine time inside the period
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      period_idx_reg <= {`TDCRF_TIME_W{1'b0}};
      since_ref_reg  <= {`TDCRF_TIME_W{1'b0}};
      tick_reg       <= {`TDCRF_TICK_W{1'b0}};
    end else begin
      tick_reg <= tick_reg + 1'b1;
      if (init_in) begin
        // Restart measurement from a clean index
        period_idx_reg <= {`TDCRF_TIME_W{1'b0}};
        since_ref_reg  <= {`TDCRF_TIME_W{1'b0}};
      end else if (ref_rise) begin
        period_idx_reg <= period_idx_reg + 1'b1;
        since_ref_reg  <= {`TDCRF_TIME_W{1'b0}};
      end else begin
        since_ref_reg <= since_ref_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Depth and latency from the resolution setting
  always @* begin
    case (resolution_boost_setting_in)
      `TDCRF_RES_X2: begin
        depth = `TDCRF_DEPTH_X2;
        lat   = LAT_X2;
      end
      `TDCRF_RES_X4: begin
        depth = `TDCRF_DEPTH_X4;
        lat   = LAT_X4;
      end
      default: begin
        depth = `TDCRF_DEPTH_OFF;
        lat   = LAT_OFF;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read selection and pop
  assign sel_oh      = 4'h1 << rd_chan_in;
  assign any_ready   = |ch_ready;
  assign all_ready   = (&(ch_ready | ~channel_active_in)) & (|channel_active_in);
  assign group_ready = joint_read_mode_in ? all_ready : any_ready;
  // Joint mode trusts the host to walk channels in ascending order
  assign rd_fire     = rd_req_in & (|(sel_oh & ch_ready)) & skid_in_ready & group_ready;
  assign rd_accept_out = rd_fire;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel buffers
  genvar c;
  generate
    for (c = 0; c < `TDCRF_CHANNELS; c = c + 1) begin : g_ch
      reg  [`TDCRF_ENTRY_W-1:0] data_mem  [0:`TDCRF_FIFO_MAX-1]; // Results
      reg  [`TDCRF_TICK_W-1:0]  stamp_mem [0:`TDCRF_FIFO_MAX-1]; // Capture ticks
      reg  [`TDCRF_PTR_W-1:0]   wr_ptr_reg;   // Next write slot
      reg  [`TDCRF_PTR_W-1:0]   rd_ptr_reg;   // Next read slot
      reg  [`TDCRF_PTR_W-1:0]   vis_ptr_reg;  // Oldest unconverted slot
      reg  [`TDCRF_CNT_W-1:0]   cnt_reg;      // Stored entries
      reg  [`TDCRF_CNT_W-1:0]   vis_reg;      // Converted entries
      reg  [1:0]                restart_reg;  // Stops still to skip
      reg                       drain_reg;    // Block drain in progress
      wire [`TDCRF_TICK_W-1:0]  age     = tick_reg - stamp_mem[vis_ptr_reg];
      wire                      stop_ev = stop_rise[c] & channel_active_in[c];
      wire                      full    = (cnt_reg >= depth);
      // Only the oldest pending entry is timed; later ones age meanwhile
      wire                      mature  = (vis_reg < cnt_reg) & (age >= lat);
      wire                      pop     = rd_fire & sel_oh[c];
      wire                      accept;

      // Full, restarting or draining buffers drop the stop
      assign accept  = stop_ev & ~full & (restart_reg == `TDCRF_RESTART_NONE) & ~drain_reg;

      assign ch_ready[c] = block_drain_mode_in ? drain_reg : (vis_reg != {`TDCRF_CNT_W{1'b0}});
      assign head_data[c*`TDCRF_ENTRY_W +: `TDCRF_ENTRY_W] = data_mem[rd_ptr_reg];
      assign fill_level_out[c*`TDCRF_CNT_W +: `TDCRF_CNT_W] = cnt_reg;

      // Storage has no reset; validity lives in the counters
      always @(posedge clock_in) begin
        if (accept) begin
          data_mem[wr_ptr_reg]  <= {period_idx_reg, since_ref_reg};
          stamp_mem[wr_ptr_reg] <= tick_reg;
        end
      end

      // Counters, pointers, restart and drain state
      always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          wr_ptr_reg  <= {`TDCRF_PTR_W{1'b0}};
          rd_ptr_reg  <= {`TDCRF_PTR_W{1'b0}};
          vis_ptr_reg <= {`TDCRF_PTR_W{1'b0}};
          cnt_reg     <= {`TDCRF_CNT_W{1'b0}};
          vis_reg     <= {`TDCRF_CNT_W{1'b0}};
          restart_reg <= `TDCRF_RESTART_NONE;
          drain_reg   <= 1'b0;
        end else if (init_in) begin
          rd_ptr_reg  <= wr_ptr_reg;
          vis_ptr_reg <= wr_ptr_reg;
          cnt_reg     <= {`TDCRF_CNT_W{1'b0}};
          vis_reg     <= {`TDCRF_CNT_W{1'b0}};
          restart_reg <= `TDCRF_RESTART_NONE;
          drain_reg   <= 1'b0;
        end else begin
          // Pointers wrap at the full array; depth only caps the count
          if (accept) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
          end
          if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
          end
          if (mature) begin
            vis_ptr_reg <= vis_ptr_reg + 1'b1;
          end
          // Fill level up per store, down per read
          cnt_reg <= cnt_reg + {{(`TDCRF_CNT_W-1){1'b0}}, accept}
                             - {{(`TDCRF_CNT_W-1){1'b0}}, pop};
          vis_reg <= vis_reg + {{(`TDCRF_CNT_W-1){1'b0}}, mature}
                             - {{(`TDCRF_CNT_W-1){1'b0}}, pop};
          // Restart skip count; arming wins over a same-cycle stop
          if (pop & full & ~block_drain_mode_in) begin
            restart_reg <= `TDCRF_RESTART_STOPS;
          end else if (pop & drain_reg & (cnt_reg == {{(`TDCRF_CNT_W-1){1'b0}}, 1'b1})) begin
            restart_reg <= `TDCRF_RESTART_STOPS;
          end else if (stop_ev & (restart_reg != `TDCRF_RESTART_NONE)) begin
            restart_reg <= restart_reg - 2'h1;
          end
          // Drain starts when every entry is converted and the buffer is full
          if (~block_drain_mode_in) begin
            drain_reg <= 1'b0;
          end else if (pop & (cnt_reg == {{(`TDCRF_CNT_W-1){1'b0}}, 1'b1})) begin
            drain_reg <= 1'b0;
          end else if (vis_reg >= depth) begin
            drain_reg <= 1'b1;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Ready pin, active low, registered
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ready_n_reg <= 1'b1;
    end else begin
      // Init forces it high; otherwise it follows group_ready, inverted, one cycle late
      ready_n_reg <= ~group_ready | init_in;
    end
  end

  assign results_ready_n_out = ready_n_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Output buffer toward the serial shifter
  tdcrf_skid u_skid (
    .clock_in      (clock_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (rd_fire),
    .in_data_in    ({rd_chan_in, head_data[rd_chan_in*`TDCRF_ENTRY_W +: `TDCRF_ENTRY_W]}),
    .in_ready_out  (skid_in_ready),
    .out_valid_out (res_valid_out),
    .out_data_out  (skid_out),
    .out_ready_in  (res_ready_in)
  );

  // Shifted out most significant byte first by the serial front end
  assign res_chan_out               = skid_out[`TDCRF_ENTRY_W+1:`TDCRF_ENTRY_W];
  assign reference_period_index_out = skid_out[`TDCRF_ENTRY_W-1:`TDCRF_TIME_W];
  assign stop_time_value_out        = skid_out[`TDCRF_TIME_W-1:0];

endmodule // tdcrf_result_fifo

// ---- tdcrf_result_fifo_properties.sv ----
`timescale 1ns/1ps
module tdcrf_rf_properties (
  // Clock, reset and pins
  input wire        clock_in,
  input wire        resetn_in,
  input wire [3:0]  stop_pin_in,
  // Configuration
  input wire [1:0]  resolution_boost_setting_in,
  input wire        block_drain_mode_in,
  input wire        joint_read_mode_in,
  input wire [3:0]  channel_active_in,
  input wire        init_in,
  // Read side
  input wire        rd_req_in,
  input wire [1:0]  rd_chan_in,
  input wire        rd_accept_out,
  input wire        res_valid_out,
  input wire        res_ready_in,
  input wire [1:0]  res_chan_out,
  input wire [23:0] reference_period_index_out,
  input wire [23:0] stop_time_value_out,
  // Status
  input wire        results_ready_n_out,
  input wire [19:0] fill_level_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Per-channel levels, depth and latency bounds
  wire [1:0] res = resolution_boost_setting_in;
  wire [4:0] lv0 = fill_level_out[4:0];
  wire [4:0] lv1 = fill_level_out[9:5];
  wire [4:0] lv2 = fill_level_out[14:10];
  wire [4:0] lv3 = fill_level_out[19:15];
  wire [4:0] lim = (res == 2'h1) ? 5'h08 : (res == 2'h2) ? 5'h04 : 5'h10;
  wire       over = (lv0 > lim) || (lv1 > lim) || (lv2 > lim) || (lv3 > lim);
  wire       at_lim = (lv0 == lim) || (lv1 == lim) || (lv2 == lim) || (lv3 == lim);
  wire [3:0] held = {lv3 != 5'h00, lv2 != 5'h00, lv1 != 5'h00, lv0 != 5'h00};
  wire [4:0] sel_lv = fill_level_out[rd_chan_in*5 +: 5];
  // Latency plus a few cycles of sync slack
  wire [8:0] lat_lim = (res == 2'h1) ? 9'h068 : (res == 2'h2) ? 9'h0cc : 9'h036;
  reg  [8:0] run_reg;
  // Cycles held since empty or a pop, plain mode; saturates
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_reg <= 9'h000;
    end else if (held == 4'h0 || rd_accept_out || init_in || block_drain_mode_in || joint_read_mode_in) begin
      run_reg <= 9'h000;
    end else if (run_reg != 9'h1ff) begin
      run_reg <= run_reg + 9'h001;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  //////////////////////////////////////////////////////////////////////////////
  // Properties
  a_reset_values:
    assert property ($rose(resetn_in) |-> results_ready_n_out && !res_valid_out && fill_level_out == 20'h00000)
    else $error("outputs not clear after reset");
  a_init_clear:
    assert property (init_in |=> results_ready_n_out && fill_level_out == 20'h00000)
    else $error("init did not clear");
  a_accept_cause:
    assert property (rd_accept_out |-> rd_req_in && sel_lv != 5'h00)
    else $error("pop without request or data");
  a_pop_level:
    assert property (rd_accept_out && !init_in && (stop_pin_in | $past(stop_pin_in, 2) | $past(stop_pin_in, 4)
      | $past(stop_pin_in, 6) | $past(stop_pin_in, 8)) == 4'h0
      |=> fill_level_out[$past(rd_chan_in)*5 +: 5] == $past(sel_lv) - 5'h01)
    else $error("pop did not lower level by one");
  a_depth_cap:
    assert property ($stable(resolution_boost_setting_in) |-> !over)
    else $error("level above depth");
  a_ready_empty:
    assert property (held == 4'h0 [*3] |-> results_ready_n_out)
    else $error("ready low with all buffers empty");
  a_ready_bound:
    assert property (run_reg >= lat_lim |-> !results_ready_n_out)
    else $error("ready late after conversion");
  a_block_full:
    assert property (block_drain_mode_in && !joint_read_mode_in && $fell(results_ready_n_out) |-> at_lim)
    else $error("block ready before full");
  a_joint_wait:
    assert property (joint_read_mode_in && (rd_accept_out || $fell(results_ready_n_out))
      |-> (held & channel_active_in) == channel_active_in)
    else $error("joint ready with an empty active channel");
  a_accept_word:
    assert property (rd_accept_out |=> res_valid_out)
    else $error("pop gave no word");
  a_word_stands:
    assert property (res_valid_out && !res_ready_in |=> res_valid_out && $stable(res_chan_out)
      && $stable(stop_time_value_out) && $stable(reference_period_index_out))
    else $error("word changed while stalled");
endmodule // tdcrf_rf_properties

bind tdcrf_result_fifo tdcrf_rf_properties tdcrf_rf_properties_i (
  .clock_in(clock_in), .resetn_in(resetn_in), .stop_pin_in(stop_pin_in),
  .resolution_boost_setting_in(resolution_boost_setting_in), .block_drain_mode_in(block_drain_mode_in),
  .joint_read_mode_in(joint_read_mode_in), .channel_active_in(channel_active_in), .init_in(init_in),
  .rd_req_in(rd_req_in), .rd_chan_in(rd_chan_in), .rd_accept_out(rd_accept_out), .res_valid_out(res_valid_out),
  .res_ready_in(res_ready_in), .res_chan_out(res_chan_out), .stop_time_value_out(stop_time_value_out),
  .reference_period_index_out(reference_period_index_out), .results_ready_n_out(results_ready_n_out),
  .fill_level_out(fill_level_out));

// ---- tdcrf_host_model.sv ----
`timescale 1ns/1ps
module tdcrf_host_model (
  // Clock and reset
  input  wire       clock_in,
  input  wire       resetn_in,
  // Bench controls
  input  wire       enable_in,
  input  wire [1:0] chan_in,
  input  wire       stall_in,
  input  wire       joint_in,
  input  wire [3:0] active_in,
  // Block side
  input  wire       results_ready_n_in,
  input  wire       rd_accept_in,
  input  wire       res_valid_in,
  input  wire [1:0] res_chan_in,
  output wire       rd_req_out,
  output wire [1:0] rd_chan_out,
  output wire       res_ready_out,
  // Tallies
  output reg  [7:0] pops_out,
  output reg  [7:0] words_out,
  output reg  [1:0] last_chan_out
);
  reg       req_reg; // Request in flight
  reg [1:0] cur_reg; // Channel asked for
  // Next active channel above c, wrapping
  function [1:0] next_active(input [1:0] c);
    integer i;
    begin
      next_active = c;
      for (i = 3; i >= 1; i = i - 1)
        if (active_in[(c + i) % 4]) next_active = c + i[1:0];
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Reads while ready is low; a cycle off after each take avoids a stray pop
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_reg       <= 1'b0;
      cur_reg       <= 2'h0;
      pops_out      <= 8'h00;
      words_out     <= 8'h00;
      last_chan_out <= 2'h0;
    end else begin
      req_reg <= enable_in && !results_ready_n_in && !rd_accept_in;
      if (!joint_in) begin
        cur_reg <= chan_in;
      end else if (rd_accept_in) begin
        cur_reg <= next_active(cur_reg);
      end
      if (rd_accept_in) begin
        pops_out <= pops_out + 8'h01;
      end
      if (res_valid_in && res_ready_out) begin
        words_out     <= words_out + 8'h01;
        last_chan_out <= res_chan_in;
      end
    end
  end
  // Idle channel lines show the inverse, never a stale value
  assign rd_req_out    = req_reg;
  assign rd_chan_out   = req_reg ? cur_reg : ~cur_reg;
  assign res_ready_out = !stall_in;
endmodule // tdcrf_host_model

// ---- test_tdcrf_result_fifo.sv ----
`timescale 1ns/1ps
module test_tdcrf_result_fifo;
  // Stimulus
  logic       clock_in = 1'b0, resetn_in = 1'b0, ref_pin = 1'b0, blk = 1'b0, jnt = 1'b0, init = 1'b0;
  logic       h_en = 1'b0, h_stall = 1'b0;
  logic [3:0] stops = 4'h0, act = 4'h1;
  logic [1:0] res = 2'h0, h_chan = 2'h0;
  // Observed
  wire        rd_req, rd_accept, res_valid, res_ready, ready_n;
  wire [1:0]  rd_chan, res_chan, last_chan;
  wire [23:0] ref_idx, stop_time;
  wire [19:0] fill;
  wire [7:0]  pops, words;
  int         err_total = 0, checks = 0, cycles = 0, n;
  // Rows: setting beside the depth and latency it gives
  logic [1:0] r_res [0:3] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [4:0] r_dep [0:3] = '{5'h10, 5'h08, 5'h04, 5'h10};
  int         r_lat [0:3] = '{50, 100, 200, 50};
  tdcrf_result_fifo tdcrf_result_fifo_i (
    .clock_in(clock_in), .resetn_in(resetn_in), .stop_pin_in(stops), .ref_clock_pin_in(ref_pin),
    .resolution_boost_setting_in(res), .block_drain_mode_in(blk), .joint_read_mode_in(jnt),
    .channel_active_in(act), .init_in(init), .rd_req_in(rd_req), .rd_chan_in(rd_chan), .rd_accept_out(rd_accept),
    .res_valid_out(res_valid), .res_ready_in(res_ready), .res_chan_out(res_chan),
    .reference_period_index_out(ref_idx), .stop_time_value_out(stop_time),
    .results_ready_n_out(ready_n), .fill_level_out(fill));
  tdcrf_host_model tdcrf_host_model_i (
    .clock_in(clock_in), .resetn_in(resetn_in), .enable_in(h_en), .chan_in(h_chan), .stall_in(h_stall),
    .joint_in(jnt), .active_in(act), .results_ready_n_in(ready_n), .rd_accept_in(rd_accept),
    .res_valid_in(res_valid), .res_chan_in(res_chan), .rd_req_out(rd_req), .rd_chan_out(rd_chan),
    .res_ready_out(res_ready), .pops_out(pops), .words_out(words), .last_chan_out(last_chan));
  //////////////////////////////////////////////////////////////////////////////
  // Clocks; reference pin free-running
  initial forever #2 clock_in = ~clock_in;
  initial begin
    #7;
    forever #16 ref_pin = ~ref_pin;
  end
  // Hang guard
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total = err_total + 1;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask
  function automatic logic [4:0] lv(input int ch);
    return fill[ch*5 +: 5];
  endfunction
  // Pulse long enough to pass the pin filter
  task automatic stop(input int ch);
    stops[ch] = 1'b1;
    tick(3);
    stops[ch] = 1'b0;
    tick(3);
  endtask
  task automatic setup(input logic [1:0] r, input logic b, input logic j, input logic [3:0] a);
    res = r;
    blk = b;
    jnt = j;
    act = a;
    init = 1'b1;
    tick(1);
    init = 1'b0;
    tick(2);
  endtask
  // Let the host take k words, bounded
  task automatic read_n(input logic [1:0] ch, input int k);
    int w;
    logic [7:0] goal;
    w = 0;
    goal = pops + k[7:0];
    h_chan = ch;
    h_en = 1'b1;
    while (pops !== goal && w < 3000) begin
      tick(1);
      w++;
    end
    h_en = 1'b0;
  endtask
  task automatic conclude();
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    tick(20);
    resetn_in = 1'b1;
    tick(2);
    // Row loop: latency, depth, overflow restart, drain
    for (int k = 0; k < 4; k++) begin
      setup(r_res[k], 1'b0, 1'b0, 4'h1);
      stops[0] = 1'b1;
      n = 0;
      while (ready_n !== 1'b0 && n < 400) begin
        tick(1);
        n++;
      end
      check("latency", n >= r_lat[k] && n <= r_lat[k] + 12, 32'h1);
      stops[0] = 1'b0;
      tick(3);
      repeat (r_dep[k] + 1) stop(0);
      tick(12);
      check("fill full", lv(0), r_dep[k]);
      read_n(2'h0, 1);
      tick(4);
      check("fill pop", lv(0), r_dep[k] - 5'h01);
      repeat (2) stop(0);
      tick(10);
      check("fill skip", lv(0), r_dep[k] - 5'h01);
      stop(0);
      tick(10);
      check("fill restart", lv(0), r_dep[k]);
      read_n(2'h0, r_dep[k]);
      tick(6);
      check("fill drained", fill, 32'h0);
      check("ready idle", ready_n, 32'h1);
    end
    // Output buffer: stall, then drain
    setup(2'h0, 1'b0, 1'b0, 4'h1);
    repeat (4) stop(0);
    tick(60);
    h_stall = 1'b1;
    h_en = 1'b1;
    tick(30);
    check("fill stalled", lv(0), 32'h2);
    check("word held", res_valid, 32'h1);
    h_stall = 1'b0;
    read_n(2'h0, 2);
    tick(6);
    check("words", words, pops);
    check("fill empty", fill, 32'h0);
    // Independent channels
    setup(2'h0, 1'b0, 1'b0, 4'hf);
    stop(1);
    stop(2);
    tick(70);
    check("levels", fill, 32'h420);
    read_n(2'h1, 1);
    tick(6);
    check("channel tag", last_chan, 32'h1);
    check("ready one left", ready_n, 32'h0);
    read_n(2'h2, 1);
    tick(6);
    check("ready none left", ready_n, 32'h1);
    // Block-wise reading at depth 4
    setup(2'h2, 1'b1, 1'b0, 4'h1);
    repeat (3) stop(0);
    tick(220);
    check("block not full", ready_n, 32'h1);
    stop(0);
    tick(220);
    check("block full", ready_n, 32'h0);
    read_n(2'h0, 1);
    stop(0);
    tick(10);
    check("drain drops", lv(0), 32'h3);
    read_n(2'h0, 3);
    repeat (2) stop(0);
    tick(10);
    check("restart drops", fill, 32'h0);
    stop(0);
    tick(10);
    check("measuring again", lv(0), 32'h1);
    // Joint reading over channels 0 and 2
    setup(2'h0, 1'b0, 1'b1, 4'h5);
    stop(0);
    stop(1);
    tick(70);
    check("joint waits", ready_n, 32'h1);
    check("inactive channel", lv(1), 32'h0);
    stop(2);
    tick(70);
    check("joint ready", ready_n, 32'h0);
    read_n(2'h0, 1);
    tick(6);
    check("joint gap", ready_n, 32'h1);
    stop(0);
    tick(70);
    read_n(2'h2, 1);
    tick(6);
    check("joint order", last_chan, 32'h2);
    check("joint left", fill, 32'h1);
    // Reset in mid-run
    resetn_in = 1'b0;
    tick(3);
    check("reset ready", ready_n, 32'h1);
    check("reset fill", fill, 32'h0);
    check("reset word", res_valid, 32'h0);
    resetn_in = 1'b1;
    tick(2);
    conclude();
  end
endmodule // test_tdcrf_result_fifo
